// >>> rtl/vsdc_regs.svh
// register map, field positions, reset values and timing counts of the setpoint control
`ifndef VSDC_REGS_SVH
`define VSDC_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define VSDC_ADDR_SETPOINT 8'h00
`define VSDC_ADDR_CTRL1 8'h04
`define VSDC_ADDR_CTRL2 8'h08
`define VSDC_ADDR_STATUS 8'h0c
`define VSDC_ADDR_REFCODE 8'h10

// ----------------------------------------------------------------
// primary control fields and reset value
// ----------------------------------------------------------------
`define VSDC_BIT_SWON 0
`define VSDC_BIT_FORCED_PULSE_WIDTH_OPERATION 1
`define VSDC_BIT_SPREAD 2
`define VSDC_BIT_DISCH 3
`define VSDC_SLEW_HI 5
`define VSDC_SLEW_LO 4
`define VSDC_SSDUR_HI 7
`define VSDC_SSDUR_LO 6
`define VSDC_CTRL1_RESET 8'h21
`define VSDC_RANGE_HI 2'b11

// ----------------------------------------------------------------
// reference grid: one unit is 0.25 mV
// ----------------------------------------------------------------
`define VSDC_BASE_LO 14'd1600
`define VSDC_BASE_HI 14'd3200
`define VSDC_MULT_R0 14'd5
`define VSDC_MULT_R1 14'd10
`define VSDC_MULT_R2 14'd20
`define VSDC_MULT_R3 14'd40
`define VSDC_SLEW_S0 14'd40
`define VSDC_SLEW_S1 14'd20
`define VSDC_SLEW_S2 14'd5
`define VSDC_SLEW_S3 14'd2
`define VSDC_SS_S0 14'd32
`define VSDC_SS_S1 14'd16
`define VSDC_SS_S2 14'd8
`define VSDC_SS_S3 14'd4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define VSDC_CLK_NS 10
`define VSDC_TICK_NS 1000
`define VSDC_TICK_CYC (`VSDC_TICK_NS / `VSDC_CLK_NS)
`define VSDC_SW_NOM 8'd40
`define VSDC_SW_SPREAD 8'd4
`define VSDC_SYNC_MIN 8'd20
`define VSDC_SYNC_MAX 8'd80
`define VSDC_SYNC_LOCK 3'd4

`endif

// >>> rtl/vsdc_pkg.sv
// types shared by the setpoint and scaling control
package vsdc_pkg;
    typedef enum logic [3:0] {
        ST_OFF  = 4'b0001,
        ST_SOFT = 4'b0010,
        ST_REG  = 4'b0100,
        ST_LOCK = 4'b1000
    } vsdc_state_t;
    typedef logic [13:0] vsdc_ref_t;
endpackage

// >>> rtl/vsdc_top.sv
// setpoint sequencing, voltage scaling, mode/sync, discharge and supply lockout control
// Operation
// R1: soft-start ramps to the strap target before any bus-programmed setpoint
// R2: setpoint, range and soft-start duration writes wait until soft-start completes
// R3: setpoint, slew and soft-start writes while disabled are kept for next enable
// R4: range 00 is 0.4 V plus 1.25 mV steps, 01 plus 2.5 mV
// R5: range 10 is 0.4 V plus 5 mV steps, 11 is 0.8 V plus 10 mV
// R6: range field resets to the strap-decoded range
// R7: new range applies only with a following setpoint write; host must write it
// R8: entering or leaving the top range flips reference between 0.4 V and 0.8 V
// R9: host changes range only at a voltage both ranges represent
// R10: setpoint changes in operation slew the reference, never jump
// R11: slew select 00/01/10/11 is 10/5/1.25/0.5 mV per us, 10 at reset
// R12: slew is absolute, independent of the selected range
// R13: static high mode pin forces PWM, static low allows power-save
// R14: a valid external clock is followed by switching and forces PWM
// R15: forced PWM is mode pin OR the forced PWM bit
// R16: in a stack each sync output drives the next mode pin
// R17: spread bit without external clock sweeps period about 10 percent triangular
// R18: with discharge bit, discharge on when disabled, switch off, thermal or lockout
// R19: no discharge until enabled once after power-up
// R20: stack secondary always discharges regardless of the discharge bit
// R21: supply low stops switching, restart through new soft-start once it recovers
// R22: during lockout the shared enable line is driven low
// R23: supply high stops switching, pulls enable low, restarts after recovery
// R24: lockout acts only on synchronised comparator flags
// R25: mode pin counts as clock only after consecutive in-band edges
`timescale 1ns/1ps
`default_nettype none
`include "vsdc_regs.svh"

module vsdc_top
    import vsdc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // decoded strap pins
    input wire logic [1:0] strapRangeSel,
    input wire logic [7:0] strapSetpoint,
    // shared enable line, mode/sync, stack
    input wire logic enIn,
    output logic enOut,
    output logic enOe,
    input wire logic modeSyncIn,
    output logic syncOut,
    input wire logic stackSecondary,
    // protection flags
    input wire logic supplyLowFlag,
    input wire logic supplyHighFlag,
    input wire logic thermalTrip,
    // converter controls
    output logic [13:0] refCode,
    output logic refHigh,
    output logic switchingOn,
    output logic forcedPwm,
    output logic spreadActive,
    output logic syncLocked,
    output logic dischargeOn,
    output logic dvsActive
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    vsdc_state_t st_r, st_nxt;
    vsdc_ref_t ref_r, strapTarget, actTarget, slewStep, ssStep;
    logic [31:0] prdata_r, readMux;
    logic pready_r, pslverr_r, mapped;
    logic strapTaken_r, pend_r, enabledOnce_r;
    logic [1:0] strapRange_r, rangeSh_r, actRange_r, ssDurAct_r;
    logic [7:0] strapCode_r, setSh_r, actSetpoint_r, ctrl1_r;
    logic lowMeta_r, lowSync_r, highMeta_r, highSync_r;
    logic enOe_r, enOut_r, refHigh_r, switchingOn_r, forcedPwm_r;
    logic spreadActive_r, syncLocked_r, dischargeOn_r, dvsActive_r, syncOut_r;
    logic [6:0] tickCnt_r;
    logic tick, runReq, lockReq, apbSetup, apbDone, wrSet, wrCtrl1, wrCtrl2;
    logic [7:0] oscCnt_r, period_r, periodCnt_r;
    logic spreadUp_r, modePrev_r, syncRise, oscHigh;
    logic [2:0] goodCnt_r;

    // ----------------------------------------------------------------
    // target arithmetic
    // ----------------------------------------------------------------
    function automatic vsdc_ref_t calcTarget(input logic [1:0] rng, input logic [7:0] code);
        vsdc_ref_t mult;
        vsdc_ref_t base;
        case (rng) // R4 R5
            2'b00: mult = `VSDC_MULT_R0;
            2'b01: mult = `VSDC_MULT_R1;
            2'b10: mult = `VSDC_MULT_R2;
            default: mult = `VSDC_MULT_R3;
        endcase
        base = (rng == `VSDC_RANGE_HI) ? `VSDC_BASE_HI : `VSDC_BASE_LO; // R8
        return 14'(base + mult * {6'h00, code});
    endfunction

    assign strapTarget = calcTarget(strapRange_r, strapCode_r);
    assign actTarget = calcTarget(actRange_r, actSetpoint_r);

    // slew is in absolute units so the range step size drops out
    always_comb begin
        case (ctrl1_r[`VSDC_SLEW_HI:`VSDC_SLEW_LO]) // R11 R12
            2'b00: slewStep = `VSDC_SLEW_S0;
            2'b01: slewStep = `VSDC_SLEW_S1;
            2'b10: slewStep = `VSDC_SLEW_S2;
            default: slewStep = `VSDC_SLEW_S3;
        endcase
        case (ssDurAct_r)
            2'b00: ssStep = `VSDC_SS_S0;
            2'b01: ssStep = `VSDC_SS_S1;
            2'b10: ssStep = `VSDC_SS_S2;
            default: ssStep = `VSDC_SS_S3;
        endcase
    end

    // ----------------------------------------------------------------
    // apb slave, answers in the first access cycle
    // ----------------------------------------------------------------
    assign apbSetup = psel & ~penable;
    assign apbDone = psel & penable & pready_r;
    assign wrSet = apbDone & pwrite & (paddr == `VSDC_ADDR_SETPOINT);
    assign wrCtrl1 = apbDone & pwrite & (paddr == `VSDC_ADDR_CTRL1);
    assign wrCtrl2 = apbDone & pwrite & (paddr == `VSDC_ADDR_CTRL2);

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            `VSDC_ADDR_SETPOINT: readMux = {24'h000000, setSh_r};
            `VSDC_ADDR_CTRL1: readMux = {24'h000000, ctrl1_r};
            `VSDC_ADDR_CTRL2: readMux = {30'h00000000, rangeSh_r};
            `VSDC_ADDR_STATUS: readMux = {20'h00000, spreadActive_r, enabledOnce_r, pend_r,
                dvsActive_r, refHigh_r, syncLocked_r, forcedPwm_r, dischargeOn_r, st_r};
            `VSDC_ADDR_REFCODE: readMux = {18'h00000, ref_r};
            default: begin
                readMux = 32'h00000000;
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= apbSetup;
            pslverr_r <= apbSetup & ~mapped;
            if (apbSetup) begin
                prdata_r <= readMux;
            end
        end
    end

    // ----------------------------------------------------------------
    // strap capture and software registers
    // ----------------------------------------------------------------
    // straps are caught in the first clocked cycle after reset release
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            strapTaken_r <= 1'b0;
            strapRange_r <= 2'b00;
            strapCode_r <= 8'h00;
        end else if (!strapTaken_r) begin
            strapTaken_r <= 1'b1;
            strapRange_r <= strapRangeSel;
            strapCode_r <= strapSetpoint;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl1_r <= `VSDC_CTRL1_RESET; // R11
            setSh_r <= 8'h00;
            rangeSh_r <= 2'b00;
        end else if (!strapTaken_r) begin
            setSh_r <= strapSetpoint;
            rangeSh_r <= strapRangeSel; // R6
        end else begin
            if (wrCtrl1) begin
                ctrl1_r <= pwdata[7:0]; // R3
            end
            if (wrSet) begin
                setSh_r <= pwdata[7:0]; // R3
            end
            if (wrCtrl2) begin
                rangeSh_r <= pwdata[1:0];
            end
        end
    end

    // a setpoint write arms the transfer; range rides along with it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
            actSetpoint_r <= 8'h00;
            actRange_r <= 2'b00;
        end else if (!strapTaken_r) begin
            actSetpoint_r <= strapSetpoint;
            actRange_r <= strapRangeSel; // R6
        end else begin
            if (pend_r && st_r != ST_SOFT) begin // R2
                actSetpoint_r <= setSh_r;
                actRange_r <= rangeSh_r; // R7
            end
            if (wrSet) begin
                pend_r <= 1'b1; // R7
            end else if (st_r != ST_SOFT) begin
                pend_r <= 1'b0;
            end
        end
    end

    // duration is frozen at soft-start entry, later writes wait
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ssDurAct_r <= 2'b00;
        end else if (st_r == ST_OFF && st_nxt == ST_SOFT) begin
            ssDurAct_r <= ctrl1_r[`VSDC_SSDUR_HI:`VSDC_SSDUR_LO]; // R2 R3
        end
    end

    // ----------------------------------------------------------------
    // lockout flag synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lowMeta_r <= 1'b0;
            lowSync_r <= 1'b0;
            highMeta_r <= 1'b0;
            highSync_r <= 1'b0;
        end else begin
            lowMeta_r <= supplyLowFlag; // R24
            lowSync_r <= lowMeta_r;
            highMeta_r <= supplyHighFlag; // R24
            highSync_r <= highMeta_r;
        end
    end

    assign lockReq = lowSync_r | highSync_r;
    assign runReq = enIn & ctrl1_r[`VSDC_BIT_SWON] & ~thermalTrip;

    // ----------------------------------------------------------------
    // sequencing state machine
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_OFF: begin
                if (lockReq) st_nxt = ST_LOCK;
                else if (runReq && strapTaken_r) st_nxt = ST_SOFT;
            end
            ST_SOFT: begin
                if (lockReq) st_nxt = ST_LOCK;
                else if (!runReq) st_nxt = ST_OFF;
                else if (ref_r == strapTarget) st_nxt = ST_REG; // R1
            end
            ST_REG: begin
                if (lockReq) st_nxt = ST_LOCK;
                else if (!runReq) st_nxt = ST_OFF;
            end
            ST_LOCK: begin
                if (!lockReq) st_nxt = ST_OFF; // R21 R23
            end
            default: st_nxt = ST_OFF;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= ST_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // reference ramp, one step per microsecond tick
    // ----------------------------------------------------------------
    assign tick = (tickCnt_r == 7'(`VSDC_TICK_CYC - 1));

    always_ff @(posedge ref_clk) begin
        if (!rst_n || tick) begin
            tickCnt_r <= 7'h00;
        end else begin
            tickCnt_r <= tickCnt_r + 7'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ref_r <= 14'h0000;
        end else begin
            case (st_r)
                ST_SOFT: begin
                    if (tick) begin // R1
                        ref_r <= (strapTarget - ref_r > ssStep) ? ref_r + ssStep : strapTarget;
                    end
                end
                ST_REG: begin
                    if (tick && ref_r < actTarget) begin // R10
                        ref_r <= (actTarget - ref_r > slewStep) ? ref_r + slewStep : actTarget;
                    end else if (tick && ref_r > actTarget) begin
                        ref_r <= (ref_r - actTarget > slewStep) ? ref_r - slewStep : actTarget;
                    end
                end
                default: ref_r <= 14'h0000; // R21 R23
            endcase
        end
    end

    // ----------------------------------------------------------------
    // external clock detection
    // ----------------------------------------------------------------
    assign syncRise = modeSyncIn & ~modePrev_r;

    // a single stray edge must not lock, so lock needs a run of good periods
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            modePrev_r <= 1'b0;
            periodCnt_r <= 8'h00;
            goodCnt_r <= 3'h0;
        end else begin
            modePrev_r <= modeSyncIn;
            if (syncRise) begin
                periodCnt_r <= 8'h00;
                if (periodCnt_r >= `VSDC_SYNC_MIN && periodCnt_r <= `VSDC_SYNC_MAX) begin
                    if (goodCnt_r != `VSDC_SYNC_LOCK) goodCnt_r <= goodCnt_r + 3'h1; // R25
                end else begin
                    goodCnt_r <= 3'h0;
                end
            end else begin
                if (periodCnt_r != 8'hff) periodCnt_r <= periodCnt_r + 8'h01;
                if (periodCnt_r > `VSDC_SYNC_MAX) goodCnt_r <= 3'h0; // R25
            end
        end
    end

    // ----------------------------------------------------------------
    // internal switching oscillator with triangular spread
    // ----------------------------------------------------------------
    assign oscHigh = (oscCnt_r < {1'b0, period_r[7:1]});

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            oscCnt_r <= 8'h00;
            period_r <= `VSDC_SW_NOM;
            spreadUp_r <= 1'b1;
        end else if (oscCnt_r >= period_r - 8'h01) begin
            oscCnt_r <= 8'h00;
            if (!spreadActive_r) begin
                period_r <= `VSDC_SW_NOM;
            end else if (spreadUp_r) begin // R17
                if (period_r >= `VSDC_SW_NOM + `VSDC_SW_SPREAD) spreadUp_r <= 1'b0;
                else period_r <= period_r + 8'h01;
            end else begin
                if (period_r <= `VSDC_SW_NOM - `VSDC_SW_SPREAD) spreadUp_r <= 1'b1;
                else period_r <= period_r - 8'h01;
            end
        end else begin
            oscCnt_r <= oscCnt_r + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            enabledOnce_r <= 1'b0;
        end else if (enIn) begin
            enabledOnce_r <= 1'b1; // R19
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            enOe_r <= 1'b0;
            enOut_r <= 1'b0;
            switchingOn_r <= 1'b0;
            refHigh_r <= 1'b0;
            dvsActive_r <= 1'b0;
        end else begin
            enOe_r <= (st_r == ST_LOCK); // R22 R23
            enOut_r <= 1'b0;
            switchingOn_r <= (st_r == ST_SOFT) || (st_r == ST_REG); // R21
            refHigh_r <= (st_r == ST_SOFT) ? (strapRange_r == `VSDC_RANGE_HI)
                                           : (actRange_r == `VSDC_RANGE_HI); // R8
            dvsActive_r <= (st_r == ST_REG) && (ref_r != actTarget);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            syncLocked_r <= 1'b0;
            forcedPwm_r <= 1'b0;
            spreadActive_r <= 1'b0;
            syncOut_r <= 1'b0;
        end else begin
            syncLocked_r <= (goodCnt_r == `VSDC_SYNC_LOCK); // R25
            forcedPwm_r <= modeSyncIn | ctrl1_r[`VSDC_BIT_FORCED_PULSE_WIDTH_OPERATION] | syncLocked_r; // R13 R14 R15
            spreadActive_r <= ctrl1_r[`VSDC_BIT_SPREAD] & ~syncLocked_r; // R17
            syncOut_r <= syncLocked_r ? modeSyncIn : oscHigh; // R14 R16
        end
    end

    // secondaries still wait for the first enable, as all devices do
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dischargeOn_r <= 1'b0;
        end else begin
            dischargeOn_r <= enabledOnce_r & (stackSecondary // R19 R20
                | (ctrl1_r[`VSDC_BIT_DISCH] & (~enIn | ~ctrl1_r[`VSDC_BIT_SWON]
                | thermalTrip | (st_r == ST_LOCK)))); // R18
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign enOut = enOut_r;
    assign enOe = enOe_r;
    assign syncOut = syncOut_r;
    assign refCode = ref_r;
    assign refHigh = refHigh_r;
    assign switchingOn = switchingOn_r;
    assign forcedPwm = forcedPwm_r;
    assign spreadActive = spreadActive_r;
    assign syncLocked = syncLocked_r;
    assign dischargeOn = dischargeOn_r;
    assign dvsActive = dvsActive_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_soft_hold;
        (st_r == ST_SOFT) |=> $stable(actSetpoint_r) && $stable(actRange_r);
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("setpoint applied in soft-start"); // R2

    property p_soft_cap;
        (st_r == ST_SOFT) |-> (ref_r <= strapTarget);
    endproperty
    a_soft_cap: assert property (p_soft_cap) else $error("soft-start passed strap target"); // R1

    property p_range_needs_write;
        (strapTaken_r && !pend_r) |=> $stable(actRange_r);
    endproperty
    a_range_needs_write: assert property (p_range_needs_write)
        else $error("range moved without setpoint write"); // R7

    property p_slew_limit;
        (st_r == ST_REG) |=> (((ref_r >= $past(ref_r)) ? (ref_r - $past(ref_r))
            : ($past(ref_r) - ref_r)) <= $past(slewStep));
    endproperty
    a_slew_limit: assert property (p_slew_limit) else $error("reference stepped too far"); // R11

    property p_forced_pulse_width_operation_or;
        (modeSyncIn || ctrl1_r[`VSDC_BIT_FORCED_PULSE_WIDTH_OPERATION]) |=> forcedPwm_r;
    endproperty
    a_forced_pulse_width_operation_or: assert property (p_forced_pulse_width_operation_or) else $error("forced pwm not set"); // R15

    property p_secondary_disch;
        (stackSecondary && enabledOnce_r) |=> dischargeOn_r;
    endproperty
    a_secondary_disch: assert property (p_secondary_disch)
        else $error("secondary not discharging"); // R20

    property p_no_disch_early;
        !enabledOnce_r |=> !dischargeOn_r;
    endproperty
    a_no_disch_early: assert property (p_no_disch_early)
        else $error("discharge before first enable"); // R19

    property p_lock_pulls_en;
        (st_r == ST_LOCK) |=> (enOe_r && !enOut_r && !switchingOn_r);
    endproperty
    a_lock_pulls_en: assert property (p_lock_pulls_en)
        else $error("enable not pulled in lockout"); // R22

    sequence s_in_lock;
        (st_r == ST_LOCK) ##1 (st_r != ST_LOCK);
    endsequence
    sequence s_restart;
        (st_r == ST_OFF) && (ref_r == 14'h0000);
    endsequence
    property p_lock_restart;
        s_in_lock |-> s_restart;
    endproperty
    a_lock_restart: assert property (p_lock_restart)
        else $error("lockout exit skipped soft-start"); // R21

    property p_ref_sel;
        (st_r == ST_REG) |=> (refHigh_r == ($past(actRange_r) == `VSDC_RANGE_HI));
    endproperty
    a_ref_sel: assert property (p_ref_sel) else $error("reference select wrong"); // R8

    property p_lock_edges;
        (goodCnt_r < `VSDC_SYNC_LOCK - 3'h1) |=> !syncLocked_r;
    endproperty
    a_lock_edges: assert property (p_lock_edges) else $error("locked on too few edges"); // R25

endmodule
`default_nettype wire

// >>> bench/vsdc_sync_src.sv
// companion device clock feeding the mode/sync input
`timescale 1ns/1ps
`default_nettype none
module vsdc_sync_src #(parameter int HALF = 20) (
    // clock and run control
    input wire logic refClk,
    input wire logic run,
    // chained sync clock
    output logic syncOut
);
    int cnt = 0;
    initial syncOut = 1'b0;
    // stands low when stopped: a static low means power-save downstream
    always @(posedge refClk) begin
        cnt <= (cnt + 1) % HALF;
        if (!run) begin
            syncOut <= 1'b0;
        end else if (cnt == HALF - 1) begin
            syncOut <= ~syncOut;
        end
    end
endmodule
`default_nettype wire

// >>> bench/vout_setpoint_dvs_control_tb.sv
// self-checking bench of the setpoint, scaling, mode and lockout control
`timescale 1ns/1ps
`default_nettype none
`include "vsdc_regs.svh"
module vout_setpoint_dvs_control_tb;
    logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic enIn = 0, modeLvl = 0, syncRun = 0, syncClk, lowF = 0, highF = 0, refHigh, syncLocked;
    logic enOe, switchingOn, forcedPwm, spreadActive, dischargeOn, dvsActive, syncOut, enOut;
    logic sec = 0, thr = 0;
    logic [13:0] refCode;
    logic [7:0] s;
    int mismatches = 0, check_count = 0;
    vsdc_sync_src SRC (.refClk(ref_clk), .run(syncRun), .syncOut(syncClk));
    vsdc_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .strapRangeSel(2'b10), .strapSetpoint(8'h14), .enIn(enIn),
        .enOut(enOut), .enOe(enOe), .modeSyncIn(modeLvl | syncClk), .syncOut(syncOut),
        .stackSecondary(sec), .supplyLowFlag(lowF), .supplyHighFlag(highF),
        .thermalTrip(thr), .refCode(refCode), .refHigh(refHigh), .switchingOn(switchingOn),
        .forcedPwm(forcedPwm), .spreadActive(spreadActive), .syncLocked(syncLocked),
        .dischargeOn(dischargeOn), .dvsActive(dvsActive));
    initial forever #5 ref_clk = ~ref_clk;
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [13:0] tgt(input logic [1:0] r, input logic [7:0] c);
        return (r == 2'b11 ? 14'd3200 : 14'd1600) + 14'(c) * (14'd5 << r);
    endfunction
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = pslverr ? 32'hffffffff : prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic waitref(input logic [13:0] v);
        for (int i = 0; i < 30000 && refCode !== v; i++) @(posedge ref_clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // a hang past the expected run length ends it as a failure
    initial begin
        wt(60000);
        mismatches++;
        give_verdict();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(68));
        wt(10);
        rst_n <= 1'b1;
        wt(2);
        apb(0, `VSDC_ADDR_CTRL2, 0);
        chk(rd, 32'h2);
        apb(0, `VSDC_ADDR_CTRL1, 0);
        chk(rd, 32'h21);
        apb(0, 8'h20, 0);
        chk(rd, 32'hffffffff);
        s = 8'($urandom % 32);
        apb(1, `VSDC_ADDR_SETPOINT, {24'h0, s});
        enIn <= 1'b1;
        waitref(tgt(2'b10, 8'h14));
        chk(refCode, tgt(2'b10, 8'h14));
        waitref(tgt(2'b10, s));
        chk(refCode, tgt(2'b10, s));
        apb(1, `VSDC_ADDR_CTRL1, 32'h01);
        // park at 0.8 V, a level both range 10 and the top range hold
        apb(1, `VSDC_ADDR_SETPOINT, 32'h50);
        wt(2);
        chk(dvsActive, 1'b1);
        waitref(14'd3200);
        apb(1, `VSDC_ADDR_CTRL2, 32'h3);
        wt(300);
        chk({refHigh, dvsActive, refCode}, {2'b00, 14'd3200});
        apb(1, `VSDC_ADDR_SETPOINT, 32'h0);
        wt(3);
        chk({refHigh, refCode}, {1'b1, 14'd3200});
        modeLvl <= 1'b1;
        wt(5);
        chk(forcedPwm, 1'b1);
        modeLvl <= 1'b0;
        wt(5);
        chk(forcedPwm, 1'b0);
        apb(1, `VSDC_ADDR_CTRL1, 32'h03);
        wt(1);
        chk(forcedPwm, 1'b1);
        apb(1, `VSDC_ADDR_CTRL1, 32'h0d);
        wt(1);
        chk(spreadActive, 1'b1);
        syncRun <= 1'b1;
        wt(400);
        chk({syncLocked, forcedPwm, spreadActive}, 3'b110);
        @(posedge syncClk);
        wt(2);
        chk(syncOut, 1'b1);
        syncRun <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            {highF, lowF} <= 2'(1 << i);
            wt(10);
            chk({enOut, enOe, switchingOn, dischargeOn}, 4'b0101);
            {highF, lowF} <= 2'b00;
            wt(20);
            chk({enOe, switchingOn}, 2'b01);
        end
        thr <= 1'b1;
        wt(3);
        chk({switchingOn, dischargeOn}, 2'b01);
        thr <= 1'b0;
        enIn <= 1'b0;
        wt(5);
        chk(dischargeOn, 1'b1);
        apb(1, `VSDC_ADDR_CTRL1, 32'h01);
        wt(1);
        chk(dischargeOn, 1'b0);
        sec <= 1'b1;
        wt(3);
        chk(dischargeOn, 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
